// >>> dprp_pkg.sv
// Shared constants and carrier types for the dual-port memory primitive
package dprp_pkg;
	// Cycles from address to registered read data
	localparam int DPRP_READ_LATENCY = 1;
	// Value of each read output bit after reset
	localparam logic DPRP_OUT_RST_BIT = 1'b0;
	// Value shown where a read result is undefined
	localparam logic DPRP_UNDEF_BIT = 1'b0;
	// Fill used for uninitialised contents when zero fill is chosen
	localparam logic DPRP_UNINIT_BIT = 1'b0;
	// Index of each interface in the per-port arrays
	localparam int DPRP_PORT_ONE = 0;
	localparam int DPRP_PORT_TWO = 1;
	localparam int DPRP_NUM_PORTS = 2;
	// Default shape of the memory
	localparam int DPRP_DEF_DEPTH = 16;
	localparam int DPRP_DEF_DATA_W = 16;
	localparam int DPRP_DEF_LANES = 1;

	// Strobes of one interface
	typedef struct packed {
		logic write_enable;
		logic read_qualifier;
	} dprp_strobe_t;
endpackage

// >>> dprp_dual_port_ram.sv
// Synchronous dual-port memory primitive with vector and complex data
// Function
// - Undefined-collision option: read of address written by other port is undefined.
// - Option enables port two writes; otherwise port two is read-only.
// - Hardware init loads initial data; otherwise contents follow uninitialised setting.
// - Qualifier low: that output unspecified, read may be suppressed.
// - Without qualifier option, reads behave as always enabled.
// - Write enable high writes that interface's data to its address.
// - One unsigned address per interface serves both read and write.
// - Each output shows data read at its own interface's address.
// - Depth equals initial vector length; all lanes share one value.
// - Matrix init: rows give entries; column count must equal lane count.
// - Data may be vector and complex; address and strobes are real.
// - Each port reads new data on its own write; the other port reads old.
// - Address beyond depth makes that interface's read output undefined.
//
// Implementation choices: the address-and-strobe port and the reset of the read outputs.
`timescale 1ns/10ps
module dprp_dual_port_ram #(
	parameter int DEPTH = dprp_pkg::DPRP_DEF_DEPTH,
	parameter int ADDR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1,
	parameter int DATA_W = dprp_pkg::DPRP_DEF_DATA_W,
	parameter int LANES = dprp_pkg::DPRP_DEF_LANES,
	parameter bit COMPLEX_EN = 1'b0,
	parameter bit UNDEF_COLLISION_OPTION = 1'b0,
	parameter bit ALLOW_WRITE_BOTH = 1'b0,
	parameter bit READ_QUAL_EN = 1'b0,
	parameter bit HW_INIT_EN = 1'b0,
	parameter bit UNINIT_ZERO = 1'b1,
	parameter bit INIT_MATRIX_EN = 1'b0,
	parameter int INIT_COLS = dprp_pkg::DPRP_DEF_LANES,
	parameter int ELEM_W = COMPLEX_EN ? 2 * DATA_W : DATA_W,
	parameter logic [DEPTH*ELEM_W-1:0] INIT_VECTOR = '0,
	parameter logic [DEPTH*LANES*ELEM_W-1:0] INIT_MATRIX = '0
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rstn,
	// Interface one
	input wire logic [ADDR_W-1:0] i_port_one_location,
	input wire logic [LANES*ELEM_W-1:0] i_port_one_write_data,
	input wire dprp_pkg::dprp_strobe_t i_port_one_strobes,
	// Interface two
	input wire logic [ADDR_W-1:0] i_port_two_location,
	input wire logic [LANES*ELEM_W-1:0] i_port_two_write_data,
	input wire dprp_pkg::dprp_strobe_t i_port_two_strobes,
	// Read data
	output logic [LANES*ELEM_W-1:0] o_port_one_read_out,
	output logic [LANES*ELEM_W-1:0] o_port_two_read_out
);
	import dprp_pkg::*;

	localparam int WORD_W = LANES * ELEM_W;
	localparam logic [ADDR_W:0] DEPTH_V = (ADDR_W + 1)'(DEPTH);
	localparam logic [WORD_W-1:0] OUT_RST = {WORD_W{DPRP_OUT_RST_BIT}};
	localparam logic [WORD_W-1:0] UNDEF_WORD = {WORD_W{DPRP_UNDEF_BIT}};

	typedef logic [WORD_W-1:0] dprp_mem_t [DEPTH];

	// Contents at configuration: loaded data, zero fill or left unknown
	function automatic dprp_mem_t init_contents();
		dprp_mem_t m;
		for (int e = 0; e < DEPTH; e++)
		begin
			for (int l = 0; l < LANES; l++)
			begin
				if (!HW_INIT_EN)
				begin
					if (UNINIT_ZERO)
					begin
						m[e][l*ELEM_W +: ELEM_W] = {ELEM_W{DPRP_UNINIT_BIT}};
					end
				end
				else if (INIT_MATRIX_EN)
				begin
					m[e][l*ELEM_W +: ELEM_W] = INIT_MATRIX[(e*LANES+l)*ELEM_W +: ELEM_W];
				end
				else
				begin
					m[e][l*ELEM_W +: ELEM_W] = INIT_VECTOR[e*ELEM_W +: ELEM_W];
				end
			end
		end
		return m;
	endfunction

	// Loaded once by its declaration, so the write process stays the only writer
	dprp_mem_t mem = init_contents();

	// Per-port views, so the read path is one loop
	logic [ADDR_W-1:0] loc [DPRP_NUM_PORTS];
	logic [WORD_W-1:0] wdata [DPRP_NUM_PORTS];
	logic we [DPRP_NUM_PORTS];
	logic rq [DPRP_NUM_PORTS];
	logic in_range [DPRP_NUM_PORTS];
	logic [WORD_W-1:0] rd_word [DPRP_NUM_PORTS];
	logic [WORD_W-1:0] q [DPRP_NUM_PORTS];
	logic [WORD_W-1:0] next_q [DPRP_NUM_PORTS];

	// Configuration checks at elaboration
	generate
		if (INIT_MATRIX_EN && (INIT_COLS != LANES))
		begin : g_bad_cols
			$error("Initial matrix column count differs from lane count");
		end
		if (DEPTH < 1)
		begin : g_bad_depth
			$error("Memory depth must be at least one");
		end
	endgenerate

	assign loc[DPRP_PORT_ONE] = i_port_one_location;
	assign loc[DPRP_PORT_TWO] = i_port_two_location;
	assign wdata[DPRP_PORT_ONE] = i_port_one_write_data;
	assign wdata[DPRP_PORT_TWO] = i_port_two_write_data;
	assign we[DPRP_PORT_ONE] = i_port_one_strobes.write_enable;
	// Port two strobe ignored unless writes on both ports are allowed
	assign we[DPRP_PORT_TWO] = ALLOW_WRITE_BOTH & i_port_two_strobes.write_enable;
	// Without the option the qualifiers act as tied high
	assign rq[DPRP_PORT_ONE] = ~READ_QUAL_EN | i_port_one_strobes.read_qualifier;
	assign rq[DPRP_PORT_TWO] = ~READ_QUAL_EN | i_port_two_strobes.read_qualifier;

	genvar p;
	generate
		for (p = 0; p < DPRP_NUM_PORTS; p++)
		begin : g_port
			localparam int OTHER = DPRP_NUM_PORTS - 1 - p;

			assign in_range[p] = {1'b0, loc[p]} < DEPTH_V;
			assign rd_word[p] = in_range[p] ? mem[loc[p]] : UNDEF_WORD;

			always_comb
			begin
				next_q[p] = q[p];
				if (!rq[p])
				begin
					next_q[p] = q[p];
				end
				else if (!in_range[p])
				begin
					next_q[p] = UNDEF_WORD;
				end
				else if (we[p])
				begin
					next_q[p] = wdata[p];
				end
				else if (UNDEF_COLLISION_OPTION && we[OTHER] && (loc[OTHER] == loc[p]))
				begin
					next_q[p] = UNDEF_WORD;
				end
				else
				begin
					next_q[p] = rd_word[p];
				end
			end

			always_ff @(posedge i_core_clk or negedge i_rstn)
			begin
				if (!i_rstn)
				begin
					q[p] <= OUT_RST;
				end
				else
				begin
					q[p] <= next_q[p];
				end
			end
		end
	endgenerate

	// Writes; port one goes last so it wins a same-address double write
	always_ff @(posedge i_core_clk)
	begin
		if (we[DPRP_PORT_TWO] && in_range[DPRP_PORT_TWO])
		begin
			mem[loc[DPRP_PORT_TWO]] <= wdata[DPRP_PORT_TWO];
		end
		if (we[DPRP_PORT_ONE] && in_range[DPRP_PORT_ONE])
		begin
			mem[loc[DPRP_PORT_ONE]] <= wdata[DPRP_PORT_ONE];
		end
	end

	assign o_port_one_read_out = q[DPRP_PORT_ONE];
	assign o_port_two_read_out = q[DPRP_PORT_TWO];

	// Checks
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rstn);

	logic same_loc;
	assign same_loc = loc[DPRP_PORT_ONE] == loc[DPRP_PORT_TWO];

	p1_write_first_a: assert property (
		rq[0] && in_range[0] && we[0] |=> o_port_one_read_out == $past(wdata[0]))
		else $error("Port one did not return its own written data");

	p2_read_old_a: assert property (
		!UNDEF_COLLISION_OPTION && rq[1] && in_range[1] && !we[1] && we[0] && same_loc
		|=> o_port_two_read_out == $past(rd_word[1]))
		else $error("Port two did not return old data during port one write");

	p2_plain_read_a: assert property (
		rq[1] && in_range[1] && !we[0] && !we[1]
		|=> o_port_two_read_out == $past(rd_word[1]))
		else $error("Port two read data wrong");

	write_store_a: assert property (
		we[0] && in_range[0]
		##1 (rq[0] && !we[0] && !we[1] && loc[0] == $past(loc[0]))
		|=> o_port_one_read_out == $past(wdata[0], 2))
		else $error("Port one write not stored");

	qual_hold_a: assert property (
		!rq[0] |=> $stable(o_port_one_read_out))
		else $error("Port one output changed while its read was suppressed");

	range_undef_a: assert property (
		rq[1] && !in_range[1] |=> o_port_two_read_out == UNDEF_WORD)
		else $error("Out of range read not shown as undefined fill");

	collide_undef_a: assert property (
		UNDEF_COLLISION_OPTION && rq[1] && in_range[1] && !we[1] && we[0] && same_loc
		|=> o_port_two_read_out == UNDEF_WORD)
		else $error("Collision read not shown as undefined fill");

	p2_read_only_a: assert property (
		!ALLOW_WRITE_BOTH && i_port_two_strobes.write_enable && in_range[1] && !we[0]
		##1 (rq[1] && !we[0] && loc[1] == $past(loc[1]))
		|=> o_port_two_read_out == $past(rd_word[1], 2))
		else $error("Port two wrote while read-only");

	always_read_a: assert property (
		!READ_QUAL_EN && !i_port_one_strobes.read_qualifier && in_range[0] && !we[0] && !we[1]
		|=> o_port_one_read_out == $past(rd_word[0]))
		else $error("Read suppressed although qualifiers are absent");

	p2_write_first_a: assert property (
		rq[1] && in_range[1] && we[1]
		|=> o_port_two_read_out == $past(wdata[1]))
		else $error("Port two did not return its own written data");

	p2_qual_hold_a: assert property (
		!rq[1] |=> $stable(o_port_two_read_out))
		else $error("Port two output changed while its read was suppressed");

	p1_range_undef_a: assert property (
		rq[0] && !in_range[0] |=> o_port_one_read_out == UNDEF_WORD)
		else $error("Port one out of range read not shown as undefined fill");

	p1_plain_read_a: assert property (
		rq[0] && in_range[0] && !we[0] && !we[1]
		|=> o_port_one_read_out == $past(rd_word[0]))
		else $error("Port one read data wrong");

	// Without the undefined-collision option, port one reading under a port two write sees old data, as port two does
	p1_read_old_a: assert property (
		!UNDEF_COLLISION_OPTION && rq[0] && in_range[0] && !we[0] && we[1] && same_loc
		|=> o_port_one_read_out == $past(rd_word[0]))
		else $error("Port one did not return old data during port two write");

	p1_collide_undef_a: assert property (
		UNDEF_COLLISION_OPTION && rq[0] && in_range[0] && !we[0] && we[1] && same_loc
		|=> o_port_one_read_out == UNDEF_WORD)
		else $error("Port one collision read not shown as undefined fill");

	// Both ports writing one entry: port one data must be kept
	dual_write_a: assert property (
		we[0] && we[1] && in_range[0] && same_loc
		##1 (rq[1] && !we[0] && !we[1] && loc[1] == $past(loc[1]))
		|=> o_port_two_read_out == $past(wdata[0], 2))
		else $error("Double write did not keep port one data");

	// Outputs must show the reset value throughout reset
	reset_out_a: assert property (@(posedge i_core_clk) disable iff (1'b0)
		!i_rstn |-> o_port_one_read_out == OUT_RST && o_port_two_read_out == OUT_RST)
		else $error("Read outputs not at reset value during reset");

	collide_read_c: cover property (we[0] && rq[1] && !we[1] && same_loc && in_range[1]);
	dual_write_c: cover property (we[0] && we[1] && in_range[0] && in_range[1]);
	write_then_read_c: cover property (we[0] && in_range[0] ##1 rq[0] && !we[0]);
	suppressed_read_c: cover property (!rq[1] ##1 rq[1]);
	range_read_c: cover property (rq[0] && !in_range[0]);
endmodule

// >>> dprp_datapath_model.sv
// Datapath model that drives both memory ports
`timescale 1ns/10ps
module dprp_datapath_model (
	// Clock
	input wire logic i_core_clk,
	// Port one drive
	output logic [3:0] o_loc_one,
	output logic [15:0] o_data_one,
	output dprp_pkg::dprp_strobe_t o_stb_one,
	// Port two drive
	output logic [3:0] o_loc_two,
	output logic [15:0] o_data_two,
	output dprp_pkg::dprp_strobe_t o_stb_two
);
	import dprp_pkg::*;
	initial
	begin
		o_loc_one = 4'h0;
		o_data_one = 16'h0;
		o_stb_one = dprp_strobe_t'(2'h1);
		o_loc_two = 4'h0;
		o_data_two = 16'h0;
		o_stb_two = dprp_strobe_t'(2'h1);
	end
	// One request on each port, applied just after an edge
	task automatic put(input logic [3:0] la, input logic [15:0] da, input logic [1:0] sa,
		input logic [3:0] lb, input logic [15:0] db, input logic [1:0] sb);
		@(posedge i_core_clk);
		o_loc_one <= la;
		o_data_one <= da;
		o_stb_one <= dprp_strobe_t'(sa);
		o_loc_two <= lb;
		o_data_two <= db;
		o_stb_two <= dprp_strobe_t'(sb);
	endtask
endmodule

// >>> tb_top.sv
// Self-checking testbench for the dual-port memory primitive
`timescale 1ns/10ps
`define CHK(nm, exp, got) \
	begin \
		total_checks++; \
		if ((got) !== (exp)) \
		begin \
			failures++; \
			$display("wrong value %s expected %h seen %h", nm, exp, got); \
		end \
	end
module tb_top;
	import dprp_pkg::*;
	function automatic logic [191:0] mk_init();
		logic [191:0] v;
		for (int e = 0; e < 12; e++)
			v[e*16 +: 16] = 16'h1100 + 16'(e);
		return v;
	endfunction
	localparam logic [191:0] INIT = mk_init();
	logic i_core_clk = 1'b0;
	logic i_rstn;
	int failures = 0;
	int total_checks = 0;
	int cycles = 0;
	logic [3:0] l1, l2;
	logic [15:0] d1, d2, q1, q2;
	dprp_strobe_t s1, s2;
	always #2.5 i_core_clk = ~i_core_clk;
	dprp_datapath_model m (.i_core_clk(i_core_clk), .o_loc_one(l1), .o_data_one(d1),
		.o_stb_one(s1), .o_loc_two(l2), .o_data_two(d2), .o_stb_two(s2));
	dprp_dual_port_ram #(.DEPTH(12), .ALLOW_WRITE_BOTH(1'b1), .READ_QUAL_EN(1'b1),
		.HW_INIT_EN(1'b1), .INIT_VECTOR(INIT)) uut (.i_core_clk(i_core_clk),
		.i_rstn(i_rstn), .i_port_one_location(l1), .i_port_one_write_data(d1),
		.i_port_one_strobes(s1), .i_port_two_location(l2), .i_port_two_write_data(d2),
		.i_port_two_strobes(s2), .o_port_one_read_out(q1), .o_port_two_read_out(q2));
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge i_core_clk)
	begin
		cycles++;
		if (cycles == 500)
		begin
			failures++;
			finish_test();
		end
	end
	task automatic settle();
		@(posedge i_core_clk);
		#1;
	endtask
	task automatic t_init();
		for (int e = 0; e < 12; e++)
		begin
			m.put(4'(e), 16'h0, 2'h1, 4'(11 - e), 16'h0, 2'h1);
			settle();
			`CHK("init p1", 16'h1100 + 16'(e), q1)
			`CHK("init p2", 16'h1100 + 16'(11 - e), q2)
		end
		$display("test init done");
	endtask
	task automatic t_collide();
		m.put(4'h3, 16'hbeef, 2'h3, 4'h3, 16'h0, 2'h1);
		settle();
		`CHK("own write p1", 16'hbeef, q1)
		`CHK("other write p2", 16'h1103, q2)
		m.put(4'h0, 16'h0, 2'h1, 4'h3, 16'h0, 2'h1);
		settle();
		`CHK("later read p2", 16'hbeef, q2)
		$display("test collide done");
	endtask
	task automatic t_port_two();
		m.put(4'h5, 16'h0, 2'h1, 4'h5, 16'h5a5a, 2'h3);
		settle();
		`CHK("own write p2", 16'h5a5a, q2)
		m.put(4'h5, 16'h0, 2'h1, 4'h4, 16'h0, 2'h1);
		settle();
		`CHK("p2 data via p1", 16'h5a5a, q1)
		$display("test port two done");
	endtask
	task automatic t_qual_range();
		m.put(4'h1, 16'h0, 2'h0, 4'h2, 16'h0, 2'h1);
		settle();
		`CHK("qualifier low p1", 16'h5a5a, q1)
		`CHK("qualifier high p2", 16'h1102, q2)
		m.put(4'hd, 16'h0, 2'h1, 4'h2, 16'h0, 2'h1);
		settle();
		`CHK("beyond depth p1", 16'h0, q1)
		$display("test qualifier and range done");
	endtask
	initial
	begin
		i_rstn <= 1'b0;
		repeat (12) @(posedge i_core_clk);
		i_rstn <= 1'b1;
		t_init();
		t_collide();
		t_port_two();
		t_qual_range();
		finish_test();
	end
endmodule
